/* File: rtl/wkd_pkg.sv */
// Purpose: shared constants and types of the wake input detect block
// Assumes: one 125 MHz clock that stands for the internal oscillator
// Notes:   filter figures are derived from the nominal wake filter time
package wkd_pkg;

   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int WKD_CLK_MHZ = 125;
   localparam int WKD_FILT_NS = 16000;  // wake_filter_time, nominal
   localparam int WKD_FILT_CYC = (WKD_FILT_NS * WKD_CLK_MHZ) / 1000;
   localparam int WKD_CNT_W = 12;

   // ----------------------------------------
   // field codes and indices
   // ----------------------------------------
   localparam logic [1:0] WKD_PULL_NONE = 2'h0;
   localparam logic [1:0] WKD_PULL_DOWN = 2'h1;
   localparam logic [1:0] WKD_PULL_UP = 2'h2;
   localparam logic [1:0] WKD_PULL_AUTO = 2'h3;
   localparam int WKD_CH_PIN = 0;
   localparam int WKD_CH_GPIO = 1;
   localparam int WKD_NCH = 2;

   // ----------------------------------------
   // power modes of the system chip
   // ----------------------------------------
   typedef enum logic [2:0] {
      WKD_NORMAL = 3'b000,
      WKD_STOP = 3'b001,
      WKD_SLEEP = 3'b010,
      WKD_FAILSAFE = 3'b011,
      WKD_INIT = 3'b100,
      WKD_RESTART = 3'b101
   } wkd_mode_t;

   // software settings of the wake input
   typedef struct packed {
      logic wake_en;          // wake_control_reg enable
      logic [1:0] pull_sel;   // pull_select_field
      logic cyclic;           // 1 cyclic sensing, 0 static
      logic meas;             // voltage_measure_select
      logic gpio_wake;        // general-purpose pin used as wake input
      logic fo_test;          // fail_output_test_bit
   } wkd_cfg_t;

   // whole state of the block
   typedef struct packed {
      logic [WKD_NCH-1:0] prev;
      logic [WKD_NCH-1:0] lvl;
      logic [WKD_NCH-1:0][WKD_CNT_W-1:0] cnt;
      logic smp;
      logic hs;
      logic stat0;
      logic stat1;
      logic lvl_stat;
      logic irq;
      logic wup;
      logic pu;
      logic pd;
      logic fo_en;
      logic fo_test;
      logic gpio_en;
      logic spi_fail;
      logic restart;
   } wkd_state_t;

endpackage

/* File: rtl/wkd_top.sv */
// Purpose: wake input detection of a high-voltage wake pin
// Assumes: inputs synchronous to CLOCK; CLOCK is the oscillator
// Notes:   wake events leave as one-cycle pulses to the mode logic
//
// Summary of operation
// - both edges of the filtered wake comparator output are wake events
// - event gives interrupt in Normal/Stop, wake-up in Sleep/Fail-Safe
// - detection mode selects static or cyclic sensing
// - static sensing filters transitions for 16 us nominal
// - each crossing restarts the filter; short pulses are dropped
// - an enable bit permits or suppresses pin wake capability
// - each pin wake event sets the primary wake status bit
// - pin level readable in Normal, Stop and Init mode
// - in cyclic sensing level status shows the last sampled level
// - gpio wake input uses 16 us filter, sets secondary status
// - pull field: 00 none, 01 down, 10 up, 11 automatic
// - automatic pull follows detected level, up when high
// - cyclic: sample while high side on, level change is an event
// - measurement disables fail output, its test, gpio and wake
// - measurement turns pulls off and blocks the wake signal
// - measurement ignores pull and control settings, writes accepted
// - measurement freezes status, level status held cleared
// - sleep request under measurement with pin only source fails
// - wake interrupt only when the source is enabled for wake
// - wake status latched until cleared; level status not latched
`timescale 1ns/1ps

module wkd_top
   import wkd_pkg::*;
#(
   parameter int FILT_CYC = WKD_FILT_CYC
) (
   // clock and reset
   input wire logic CLOCK,
   input wire logic SYS_RST,
   // comparator levels and timing
   input wire logic PIN_IN,
   input wire logic GPIO_IN,
   input wire logic HS_ON,
   // settings and mode
   input wire wkd_cfg_t CFG,
   input wire wkd_mode_t MODE,
   // software clears of wake status
   input wire logic CLR_PRIMARY,
   input wire logic CLR_SECONDARY,
   // sleep request check
   input wire logic SLEEP_REQ,
   input wire logic OTHER_WAKE_SRC,
   // wake signalling
   output logic WAKE_IRQ,
   output logic WAKE_UP,
   // status
   output logic STAT_PRIMARY,
   output logic STAT_SECONDARY,
   output logic LEVEL_STATUS,
   // pull sources
   output logic PULL_UP_EN,
   output logic PULL_DN_EN,
   // shared pin functions
   output logic FAIL_OUT_EN,
   output logic FAIL_TEST_OUT,
   output logic GPIO_EN,
   // sleep refusal
   output logic SPI_FAIL_SET,
   output logic RESTART_REQ
);

   localparam logic [WKD_CNT_W-1:0] TGT = WKD_CNT_W'(FILT_CYC - 1);

   wkd_state_t q;
   wkd_state_t d;
   logic [WKD_NCH-1:0] in;
   logic [WKD_NCH-1:0] ev;
   logic [WKD_NCH-1:0] ch_on;
   logic win_end;
   logic lvl_now;

   // -----------------------------------------------------------
   // helpers
   // -----------------------------------------------------------
   function automatic logic awake_mode(input wkd_mode_t m);
      awake_mode = (m == WKD_NORMAL) || (m == WKD_STOP);
   endfunction

   function automatic logic low_power(input wkd_mode_t m);
      low_power = (m == WKD_SLEEP) || (m == WKD_FAILSAFE);
   endfunction

   // -----------------------------------------------------------
   // next state
   // -----------------------------------------------------------
   always_comb begin
      d = q;
      in[WKD_CH_PIN] = PIN_IN;
      in[WKD_CH_GPIO] = GPIO_IN;
      ev = '0;
      // measurement blocks both pins; gpio only when set as wake
      ch_on[WKD_CH_PIN] = !CFG.meas;
      ch_on[WKD_CH_GPIO] = !CFG.meas && CFG.gpio_wake;
      win_end = q.hs && !HS_ON;
      d.hs = HS_ON;
      // deglitch counters, both channels alike except the pin in cyclic sensing, whose counter stays at zero
      for (int i = 0; i < WKD_NCH; i++) begin
         d.prev[i] = in[i];
         if (!ch_on[i] || (i == WKD_CH_PIN && CFG.cyclic)) begin
            d.cnt[i] = '0;
         end else if (in[i] != q.prev[i]) begin
            d.cnt[i] = '0;
         end else if (q.prev[i] != q.lvl[i]) begin
            if (q.cnt[i] == TGT) begin
               d.lvl[i] = q.prev[i];
               d.cnt[i] = '0;
               ev[i] = 1'b1;
            end else begin
               d.cnt[i] = q.cnt[i] + 1'b1;
            end
         end
      end
      // cyclic sensing samples while the high side is on
      if (ch_on[WKD_CH_PIN] && CFG.cyclic) begin
         if (HS_ON) begin
            d.smp = PIN_IN;
         end
         if (win_end && q.smp != q.lvl[WKD_CH_PIN]) begin
            d.lvl[WKD_CH_PIN] = q.smp;
            ev[WKD_CH_PIN] = 1'b1;
         end
      end
      // suppressed wake capability yields no event
      ev[WKD_CH_PIN] = ev[WKD_CH_PIN] && CFG.wake_en;
      // signalling by power mode
      d.irq = (|ev) && awake_mode(MODE);
      d.wup = (|ev) && low_power(MODE);
      // sticky status, set wins over clear
      d.stat0 = ev[WKD_CH_PIN] || (q.stat0 && !CLR_PRIMARY);
      d.stat1 = ev[WKD_CH_GPIO] || (q.stat1 && !CLR_SECONDARY);
      // level status follows the level, no latching
      lvl_now = d.lvl[WKD_CH_PIN];
      if (CFG.meas) begin
         d.lvl_stat = 1'b0;
      end else if (awake_mode(MODE) || MODE == WKD_INIT) begin
         d.lvl_stat = lvl_now;
      end
      // pull current sources
      d.pu = 1'b0;
      d.pd = 1'b0;
      if (!CFG.meas) begin
         case (CFG.pull_sel)
            WKD_PULL_NONE: begin
               d.pu = 1'b0;
            end
            WKD_PULL_DOWN: begin
               d.pd = 1'b1;
            end
            WKD_PULL_UP: begin
               d.pu = 1'b1;
            end
            WKD_PULL_AUTO: begin
               d.pu = lvl_now;
               d.pd = !lvl_now;
            end
            default: begin
               d.pu = 1'b0;
            end
         endcase
      end
      // shared pin functions released while measuring
      d.fo_en = !CFG.meas;
      d.fo_test = CFG.fo_test && !CFG.meas;
      d.gpio_en = !CFG.meas;
      // sleep refused when only the pin could wake
      d.spi_fail = SLEEP_REQ && CFG.meas && !OTHER_WAKE_SRC;
      d.restart = d.spi_fail;
   end

   // -----------------------------------------------------------
   // state register
   // -----------------------------------------------------------
   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // outputs straight from the state register
   assign WAKE_IRQ = q.irq;
   assign WAKE_UP = q.wup;
   assign STAT_PRIMARY = q.stat0;
   assign STAT_SECONDARY = q.stat1;
   assign LEVEL_STATUS = q.lvl_stat;
   assign PULL_UP_EN = q.pu;
   assign PULL_DN_EN = q.pd;
   assign FAIL_OUT_EN = q.fo_en;
   assign FAIL_TEST_OUT = q.fo_test;
   assign GPIO_EN = q.gpio_en;
   assign SPI_FAIL_SET = q.spi_fail;
   assign RESTART_REQ = q.restart;

   // -----------------------------------------------------------
   // assertions
   // -----------------------------------------------------------
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (SYS_RST);

   sequence s_bad_sleep;
      SLEEP_REQ && CFG.meas && !OTHER_WAKE_SRC;
   endsequence

   sequence s_win_change;
      CFG.cyclic && !CFG.meas && win_end && (q.smp != q.lvl[0]);
   endsequence

   property p_full_filter;
      (ev[0] && !CFG.cyclic) |-> (q.cnt[0] == TGT);
   endproperty
   a_full_filter: assert property (p_full_filter)
      else $error("pin event before full filter time");

   property p_restart;
      (!CFG.meas && !CFG.cyclic && PIN_IN != q.prev[0]) |=> q.cnt[0] == 0;
   endproperty
   a_restart: assert property (p_restart)
      else $error("filter not restarted on crossing");

   property p_irq_mode;
      (|ev && awake_mode(MODE)) |=> WAKE_IRQ && !WAKE_UP;
   endproperty
   a_irq_mode: assert property (p_irq_mode)
      else $error("event in awake mode gave no interrupt");

   property p_wup_mode;
      (|ev && low_power(MODE)) |=> WAKE_UP && !WAKE_IRQ;
   endproperty
   a_wup_mode: assert property (p_wup_mode)
      else $error("event in low power gave no wake-up");

   property p_disabled;
      !CFG.wake_en |-> !ev[0];
   endproperty
   a_disabled: assert property (p_disabled)
      else $error("pin event while wake disabled");

   property p_stat_set;
      ev[0] |=> STAT_PRIMARY ##1 (STAT_PRIMARY || $past(CLR_PRIMARY));
   endproperty
   a_stat_set: assert property (p_stat_set)
      else $error("primary status not set and held");

   property p_stat_hold;
      (STAT_PRIMARY && !CLR_PRIMARY) |=> STAT_PRIMARY;
   endproperty
   a_stat_hold: assert property (p_stat_hold)
      else $error("primary status dropped without clear");

   property p_gpio_stat;
      ev[1] |-> CFG.gpio_wake && !CFG.meas ##1 STAT_SECONDARY;
   endproperty
   a_gpio_stat: assert property (p_gpio_stat)
      else $error("gpio event lost");

   property p_meas_off;
      CFG.meas |=> !LEVEL_STATUS && !PULL_UP_EN && !PULL_DN_EN && !GPIO_EN
         && !FAIL_OUT_EN && !FAIL_TEST_OUT;
   endproperty
   a_meas_off: assert property (p_meas_off)
      else $error("pin functions active while measuring");

   property p_auto;
      (!CFG.meas && CFG.pull_sel == WKD_PULL_AUTO) |=>
         PULL_UP_EN == $past(lvl_now) && PULL_DN_EN != PULL_UP_EN;
   endproperty
   a_auto: assert property (p_auto)
      else $error("automatic pull not following level");

   property p_cyclic;
      s_win_change |=> q.lvl[0] == $past(q.smp);
   endproperty
   a_cyclic: assert property (p_cyclic)
      else $error("window change not taken as level");

   property p_sleep_fail;
      s_bad_sleep |=> SPI_FAIL_SET && RESTART_REQ;
   endproperty
   a_sleep_fail: assert property (p_sleep_fail)
      else $error("sleep under measurement not refused");

   // a clear with no event in the same cycle drops the bit
   property p_clr_primary;
      (CLR_PRIMARY && !ev[0]) |=> !STAT_PRIMARY;
   endproperty
   a_clr_primary: assert property (p_clr_primary)
      else $error("primary status not cleared");

   // level status tracks the filtered level in the readable modes
   property p_lvl_stat;
      (!CFG.meas && (awake_mode(MODE) || MODE == WKD_INIT)) |=>
         LEVEL_STATUS == q.lvl[0];
   endproperty
   a_lvl_stat: assert property (p_lvl_stat)
      else $error("level status not following level");

   // measurement never sets the primary status
   property p_meas_freeze;
      (CFG.meas && !STAT_PRIMARY) |=> !STAT_PRIMARY;
   endproperty
   a_meas_freeze: assert property (p_meas_freeze)
      else $error("primary status set while measuring");

endmodule

/* File: bench/wkd_line.sv */
// Purpose: model of the external wake signal line
// Assumes: the bench changes drv and lvl at the falling edge
// Notes:   a released line follows the pulls, else it wanders
`timescale 1ns/1ps
module wkd_line (
   // control from the bench
   input wire logic clk,
   input wire logic drv,
   input wire logic lvl,
   // pull sources of the device
   input wire logic pu,
   input wire logic pd,
   // line level seen by the comparator
   output logic pin
);
   logic flt = 1'h0;
   // an open line without pull flips every cycle
   always @(negedge clk) flt <= ~flt;
   assign pin = drv ? lvl : pu ? 1'h1 : pd ? 1'h0 : flt;
endmodule

/* File: bench/wake_input_detect_tb.sv */
// Purpose: self-checking bench of the wake input detect block
// Assumes: short filter parameter, inputs change at falling edge
// Notes:   wake pulses are matched against a queue of expectations
`timescale 1ns/1ps
module wake_input_detect_tb import wkd_pkg::*;;
   localparam int F = 8;
   logic CLOCK = 1'h0, SYS_RST = 1'h1, HS_ON = 1'h0, GPIO_IN = 1'h0;
   logic CLR_PRIMARY = 1'h0, CLR_SECONDARY = 1'h0, SLEEP_REQ = 1'h0;
   logic OTHER_WAKE_SRC = 1'h0, drv = 1'h1, lvl = 1'h0, PIN_IN;
   logic WAKE_IRQ, WAKE_UP, STAT_PRIMARY, STAT_SECONDARY, LEVEL_STATUS;
   logic PULL_UP_EN, PULL_DN_EN, FAIL_OUT_EN, FAIL_TEST_OUT, GPIO_EN;
   logic SPI_FAIL_SET, RESTART_REQ;
   wkd_cfg_t cfg = '0;
   wkd_mode_t mode = WKD_NORMAL;
   logic [1:0] q[$];
   logic [31:0] rnd = 32'h103c_2a04;
   int n_errors = 0, check_count = 0, cycles = 0, k;

   // ----------------------------------------
   // clock, design and line model
   // ----------------------------------------
   always #4 CLOCK = ~CLOCK;
   wkd_top #(.FILT_CYC(F)) u_wkd_top (.CLOCK(CLOCK), .SYS_RST(SYS_RST),
      .PIN_IN(PIN_IN), .GPIO_IN(GPIO_IN), .HS_ON(HS_ON), .CFG(cfg),
      .MODE(mode), .CLR_PRIMARY(CLR_PRIMARY),
      .CLR_SECONDARY(CLR_SECONDARY), .SLEEP_REQ(SLEEP_REQ),
      .OTHER_WAKE_SRC(OTHER_WAKE_SRC), .WAKE_IRQ(WAKE_IRQ),
      .WAKE_UP(WAKE_UP), .STAT_PRIMARY(STAT_PRIMARY),
      .STAT_SECONDARY(STAT_SECONDARY), .LEVEL_STATUS(LEVEL_STATUS),
      .PULL_UP_EN(PULL_UP_EN), .PULL_DN_EN(PULL_DN_EN),
      .FAIL_OUT_EN(FAIL_OUT_EN), .FAIL_TEST_OUT(FAIL_TEST_OUT),
      .GPIO_EN(GPIO_EN), .SPI_FAIL_SET(SPI_FAIL_SET),
      .RESTART_REQ(RESTART_REQ));
   wkd_line u_wkd_line (.clk(CLOCK), .drv(drv), .lvl(lvl),
      .pu(PULL_UP_EN), .pd(PULL_DN_EN), .pin(PIN_IN));

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task cyc(input int n);
      repeat (n) @(negedge CLOCK);
   endtask
   task cmp(input logic [4:0] g, input logic [4:0] e);
      check_count++;
      if (g !== e) begin
         n_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task chk_ev(input logic [1:0] g, input logic [1:0] e);
      cmp({3'h0, g}, {3'h0, e});
   endtask
   task chk_st(input logic [4:0] g, input logic [4:0] e);
      cmp(g, e);
   endtask
   task note(input string s);
      $display("test %s done", s);
   endtask
   // drive a line edge and note the wake pulse it should give
   task ev(input logic v, input logic [1:0] e);
      if (e !== 2'h0) q.push_back(e);
      lvl = v;
      cyc(F + 3);
   endtask
   task clr(input logic p);
      CLR_PRIMARY = p;
      CLR_SECONDARY = ~p;
      cyc(1);
      CLR_PRIMARY = 1'h0;
      CLR_SECONDARY = 1'h0;
   endtask
   task end_sim;
      chk_st({4'h0, q.size() != 0}, 5'h0);
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // wake pulse monitor, {up, irq}
   always @(negedge CLOCK) begin
      if (!SYS_RST && {WAKE_UP, WAKE_IRQ} !== 2'h0)
         chk_ev({WAKE_UP, WAKE_IRQ}, q.size() ? q.pop_front() : 2'h0);
   end
   // hang guard
   always @(posedge CLOCK) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         n_errors++;
         end_sim();
      end
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      cyc(16);
      SYS_RST = 1'h0;
      cyc(3);
      chk_st({FAIL_OUT_EN, GPIO_EN, STAT_PRIMARY, 2'h0}, 5'h18);
      cfg.fo_test = 1'h1;
      cfg.wake_en = 1'h1;
      cyc(2);
      chk_st({4'h0, FAIL_TEST_OUT}, 5'h1);
      ev(1'h1, 2'h1);
      chk_st({3'h0, STAT_PRIMARY, LEVEL_STATUS}, 5'h3);
      for (k = 0; k < 4; k++) begin
         rnd = lfsr(rnd);
         lvl = 1'h0;
         cyc(1 + rnd % (F - 1));
         ev(1'h1, 2'h0);
      end
      chk_st({4'h0, LEVEL_STATUS}, 5'h1);
      clr(1'h1);
      chk_st({4'h0, STAT_PRIMARY}, 5'h0);
      note("static");
      for (k = 0; k < 6; k++) begin
         mode = wkd_mode_t'(k);
         ev(~lvl, k < 2 ? 2'h1 : k < 4 ? 2'h2 : 2'h0);
      end
      clr(1'h1);
      cfg.wake_en = 1'h0;
      mode = WKD_INIT;
      ev(1'h0, 2'h0);
      chk_st({3'h0, STAT_PRIMARY, LEVEL_STATUS}, 5'h0);
      mode = WKD_NORMAL;
      cfg.wake_en = 1'h1;
      cfg.gpio_wake = 1'h1;
      q.push_back(2'h1);
      GPIO_IN = 1'h1;
      cyc(F + 3);
      chk_st({3'h0, STAT_SECONDARY, STAT_PRIMARY}, 5'h2);
      clr(1'h0);
      chk_st({4'h0, STAT_SECONDARY}, 5'h0);
      note("modes");
      for (k = 0; k < 4; k++) begin
         cfg.pull_sel = k[1:0];
         cyc(2);
         chk_st({3'h0, PULL_UP_EN, PULL_DN_EN}, {3'h0, k == 2 || k == 3 &&
            lvl, k == 1 || k == 3 && !lvl});
      end
      drv = 1'h0;
      cyc(F + 3);
      drv = 1'h1;
      ev(1'h1, 2'h1);
      chk_st({3'h0, PULL_UP_EN, PULL_DN_EN}, 5'h2);
      note("pulls");
      cfg.cyclic = 1'h1;
      cyc(2);
      lvl = 1'h0;
      cyc(F + 3);
      chk_st({4'h0, LEVEL_STATUS}, 5'h1);
      HS_ON = 1'h1;
      cyc(1);
      HS_ON = 1'h0;
      q.push_back(2'h1);
      cyc(3);
      chk_st({4'h0, LEVEL_STATUS}, 5'h0);
      note("cyclic");
      clr(1'h1);
      cfg.meas = 1'h1;
      cyc(1);
      cfg.cyclic = 1'h0;
      GPIO_IN = 1'h0;
      ev(1'h1, 2'h0);
      chk_st({PULL_UP_EN, PULL_DN_EN, LEVEL_STATUS, FAIL_OUT_EN, GPIO_EN},
         5'h0);
      chk_st({3'h0, FAIL_TEST_OUT, STAT_PRIMARY}, 5'h0);
      cfg.pull_sel = WKD_PULL_UP;
      ev(1'h0, 2'h0);
      chk_st({3'h0, PULL_UP_EN, STAT_PRIMARY}, 5'h0);
      for (k = 0; k < 2; k++) begin
         OTHER_WAKE_SRC = (k == 0);
         SLEEP_REQ = 1'h1;
         cyc(1);
         SLEEP_REQ = 1'h0;
         chk_st({3'h0, SPI_FAIL_SET, RESTART_REQ}, k ? 5'h3 : 5'h0);
         cyc(1);
      end
      note("measure");
      end_sim();
   end
endmodule
